// *** logic/irg_router.sv ***
`timescale 1ns/1ps
`default_nettype none
module irg_router (
   // clock and reset
   input  wire logic                        clk_in,
   input  wire logic                        rst_in,
   // interrupt sources, asynchronous, rising edge sets pending
   input  wire logic [irg_pkg::NUM_IRQ-1:0] src_in,
   // register port
   input  wire logic [irg_pkg::ADDR_W-1:0]  addr_in,
   input  wire logic [31:0]                 wdata_in,
   input  wire logic                        wr_in,
   input  wire logic                        rd_in,
   output logic      [31:0]                 rdata_out,
   // processor requests and event interrupt
   output logic                             irq_out,
   output logic                             fiq_out,
   output logic                             int_out
);
   irg_pkg::irg_state_t   st_q;
   irg_pkg::irg_state_t   st_d;
   irg_pkg::irg_bus_req_t req;
   logic [irg_pkg::NUM_IRQ-1:0] grp_vec;
   logic                        grp_wr;
   logic [5:0]                  hp_sel;
   logic [5:0]                  run_sel;
   logic [4:0]                  hp_id;
   logic [7:0]                  hp_prio;
   logic [7:0]                  run_prio;
   logic                        hp_grp;
   logic [2:0]                  bp_g1;
   logic [7:0]                  pre_mask;
   logic                        preempt;
   logic                        cand0;
   logic                        cand1;
   logic                        sig0;
   logic                        sig1;

   function automatic logic [5:0] first_set(input logic [irg_pkg::NUM_IRQ-1:0] v);
      logic [5:0] r;
      r = 6'h00;
      for (int i = irg_pkg::NUM_IRQ - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, 5'(i)};
         end
      end
      return r;
   endfunction

   // fixed priority: lower id is more urgent
   function automatic logic [7:0] prio_of(input logic [4:0] id);
      return {id, 3'h0};
   endfunction

   function automatic logic [7:0] bp_mask(input logic [2:0] bp, input logic g1);
      logic [3:0] sh;
      sh = g1 ? {1'b0, bp} : 4'({1'b0, bp} + 4'h1);
      return 8'hFF << sh;
   endfunction

   assign req    = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
   assign grp_wr = req.wr && (req.addr == irg_pkg::OFF_GROUP_ASGN);

   irg_grp_store u_store (
      .clk_in     (clk_in),
      .rst_in     (rst_in),
      .wr_in      (grp_wr),
      .wdata_in   (req.wdata),
      .groups_out (grp_vec)
   );

   // candidate selection
   always_comb begin
      hp_sel   = first_set(st_q.pending);
      run_sel  = first_set(st_q.active);
      hp_id    = hp_sel[4:0];
      hp_prio  = prio_of(hp_id);
      run_prio = run_sel[5] ? prio_of(run_sel[4:0]) : irg_pkg::RUN_PRIO_IDLE;
      hp_grp   = grp_vec[hp_id];
      bp_g1    = st_q.cctl.common_binary_point ? st_q.bp0 : st_q.bp1;
      pre_mask = hp_grp ? bp_mask(bp_g1, !st_q.cctl.common_binary_point)
                        : bp_mask(st_q.bp0, 1'b0);
      preempt  = !run_sel[5] || (hp_prio < (run_prio & pre_mask));
      cand0    = hp_sel[5] && (hp_prio < st_q.pmr) && preempt && !hp_grp
                 && st_q.dctl.group0_enable;
      cand1    = hp_sel[5] && (hp_prio < st_q.pmr) && preempt && hp_grp
                 && st_q.dctl.group1_enable;
      sig0     = cand0 && st_q.cctl.group0_enable;
      sig1     = cand1 && st_q.cctl.group1_enable;
   end

   always_comb begin
      logic [9:0]                  eoi_id;
      logic                        eoi_hit;
      logic                        eoi_g;
      logic [irg_pkg::NUM_IRQ-1:0] set_p;
      logic [irg_pkg::NUM_IRQ-1:0] clr_p;
      logic [irg_pkg::NUM_IRQ-1:0] set_a;
      logic [irg_pkg::NUM_IRQ-1:0] clr_a;
      logic [1:0]                  evt;
      logic [9:0]                  ack_id;
      eoi_id  = req.wdata[9:0];
      eoi_hit = (eoi_id < 10'(irg_pkg::NUM_IRQ)) && st_q.active[eoi_id[4:0]];
      eoi_g   = grp_vec[eoi_id[4:0]];
      set_p   = '0;
      clr_p   = '0;
      set_a   = '0;
      clr_a   = '0;
      evt     = 2'h0;
      ack_id  = irg_pkg::ID_SPURIOUS;
      st_d    = st_q;

      // first flop feeds only the second
      st_d.src_s1   = src_in;
      st_d.src_s2   = st_q.src_s1;
      st_d.src_prev = st_q.src_s2;
      set_p         = st_q.src_s2 & ~st_q.src_prev;

      st_d.rdata = 32'h0000_0000;
      if (req.rd) begin
         unique case (req.addr)
            irg_pkg::OFF_DIST_CTRL:  st_d.rdata = 32'(st_q.dctl);
            irg_pkg::OFF_GROUP_ASGN: st_d.rdata = grp_vec;
            irg_pkg::OFF_PENDING:    st_d.rdata = st_q.pending;
            irg_pkg::OFF_CPU_CTRL:   st_d.rdata = 32'(st_q.cctl);
            irg_pkg::OFF_PRIO_MASK:  st_d.rdata = 32'(st_q.pmr);
            irg_pkg::OFF_BP_GRP0:    st_d.rdata = 32'(st_q.bp0);
            irg_pkg::OFF_BP_GRP1:    st_d.rdata = 32'(st_q.bp1);
            irg_pkg::OFF_RUN_PRIO:   st_d.rdata = 32'(run_prio);
            irg_pkg::OFF_HP_PEND:    st_d.rdata = 32'((cand0 || cand1) ? 10'(hp_id)
                                                         : irg_pkg::ID_SPURIOUS);
            irg_pkg::OFF_EVT_STAT:   st_d.rdata = 32'(st_q.evt_stat);
            irg_pkg::OFF_EVT_MASK:   st_d.rdata = 32'(st_q.evt_mask);
            irg_pkg::OFF_ACK_GRP0: begin
               if (sig0 || (sig1 && st_q.cctl.ack_control_legacy)) begin
                  ack_id = 10'(hp_id);
               end else if (sig1) begin
                  ack_id = irg_pkg::ID_WRONG_GRP;
               end
               st_d.rdata = 32'(ack_id);
            end
            irg_pkg::OFF_ACK_GRP1: begin
               if (sig1) begin
                  ack_id = 10'(hp_id);
               end
               st_d.rdata = 32'(ack_id);
            end
            // write-only completion registers give nothing usable
            default:                 st_d.rdata = 32'h0000_0000;
         endcase
         if ((req.addr == irg_pkg::OFF_ACK_GRP0) || (req.addr == irg_pkg::OFF_ACK_GRP1)) begin
            if (ack_id[9:5] == 5'h00) begin
               clr_p[ack_id[4:0]] = 1'b1;
               set_a[ack_id[4:0]] = 1'b1;
            end else begin
               evt[irg_pkg::EVT_SPURIOUS_ACK] = 1'b1;
            end
         end
      end

      // read-only addresses fall through untouched
      if (req.wr) begin
         unique case (req.addr)
            irg_pkg::OFF_DIST_CTRL: st_d.dctl     = req.wdata[1:0];
            irg_pkg::OFF_CPU_CTRL:  st_d.cctl     = req.wdata[4:0];
            irg_pkg::OFF_PRIO_MASK: st_d.pmr      = req.wdata[7:0];
            irg_pkg::OFF_BP_GRP0:   st_d.bp0      = req.wdata[2:0];
            irg_pkg::OFF_BP_GRP1:   st_d.bp1      = req.wdata[2:0];
            irg_pkg::OFF_EVT_MASK:  st_d.evt_mask = req.wdata[1:0];
            irg_pkg::OFF_EOI_GRP0: begin
               if (eoi_hit && (!eoi_g || st_q.cctl.ack_control_legacy)) begin
                  clr_a[eoi_id[4:0]] = 1'b1;
               end else begin
                  evt[irg_pkg::EVT_BAD_EOI] = 1'b1;
               end
            end
            irg_pkg::OFF_EOI_GRP1: begin
               if (eoi_hit && eoi_g) begin
                  clr_a[eoi_id[4:0]] = 1'b1;
               end else begin
                  evt[irg_pkg::EVT_BAD_EOI] = 1'b1;
               end
            end
            default: ;
         endcase
      end

      // a new edge beats an acknowledge in the same cycle
      st_d.pending = (st_q.pending & ~clr_p) | set_p;
      st_d.active  = (st_q.active & ~clr_a) | set_a;
      st_d.evt_stat = st_q.evt_stat;
      if (req.wr && (req.addr == irg_pkg::OFF_EVT_STAT)) begin
         st_d.evt_stat = st_q.evt_stat & ~req.wdata[1:0];
      end
      st_d.evt_stat = st_d.evt_stat | evt;

      st_d.fiq  = sig0 && st_q.cctl.fiq_select_grp0;
      st_d.irq  = (sig0 && !st_q.cctl.fiq_select_grp0) || sig1;
      st_d.intr = |(st_d.evt_stat & st_q.evt_mask);
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         st_q          <= '0;
         st_q.pmr      <= irg_pkg::PMR_RESET;
         st_q.bp0      <= irg_pkg::BP_RESET;
         st_q.bp1      <= irg_pkg::BP_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   assign rdata_out = st_q.rdata;
   assign irq_out   = st_q.irq;
   assign fiq_out   = st_q.fiq;
   assign int_out   = st_q.intr;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   sequence s_ack0_legacy_off;
      rd_in && (addr_in == irg_pkg::OFF_ACK_GRP0) && !st_q.cctl.ack_control_legacy;
   endsequence

   sequence s_ack1_read;
      rd_in && (addr_in == irg_pkg::OFF_ACK_GRP1);
   endsequence

   sequence s_eoi1_valid;
      wr_in && (addr_in == irg_pkg::OFF_EOI_GRP1) && (wdata_in[9:5] == 5'h00)
      && st_q.active[wdata_in[4:0]] && grp_vec[wdata_in[4:0]];
   endsequence

   sequence s_eoi0_valid;
      wr_in && (addr_in == irg_pkg::OFF_EOI_GRP0) && (wdata_in[9:5] == 5'h00)
      && st_q.active[wdata_in[4:0]] && !grp_vec[wdata_in[4:0]];
   endsequence

   a_reset_groups: assert property (disable iff (1'b0) rst_in |=> grp_vec == '0)
      else $error("group bits not cleared by reset");
   a_group_write: assert property (grp_wr |=> grp_vec == $past(wdata_in))
      else $error("group assignment write lost");
   a_fiq_route: assert property (fiq_out |-> $past(st_q.cctl.fiq_select_grp0)
                                 && $past(st_q.dctl.group0_enable) && !$past(hp_grp))
      else $error("fiq raised without group 0 fiq routing");
   a_irq_fallback: assert property (!st_q.cctl.fiq_select_grp0 |=> !fiq_out)
      else $error("fiq raised while fiq select clear");
   a_dist_gate: assert property ((!st_q.dctl.group0_enable && !st_q.dctl.group1_enable)[*2]
                                 |-> !irq_out && !fiq_out)
      else $error("request while distributor groups disabled");
   a_cpu_gate: assert property ((irq_out || fiq_out) |->
                                $past(hp_grp ? st_q.cctl.group1_enable
                                             : st_q.cctl.group0_enable))
      else $error("request for a group disabled in the cpu interface");
   a_grp0_dist: assert property (fiq_out |-> $past(st_q.dctl.group0_enable))
      else $error("group 0 signalled with distributor group 0 off");
   a_ack_grp0: assert property (s_ack0_legacy_off ##0 sig0 |=>
                                rdata_out == 32'($past(hp_id)) && st_q.active[$past(hp_id)])
      else $error("primary ack did not take group 0 interrupt");
   a_ack_wrong: assert property (s_ack0_legacy_off ##0 (!sig0 && sig1) |=>
                                 rdata_out == 32'(irg_pkg::ID_WRONG_GRP))
      else $error("primary ack took group 1 outside legacy mode");
   a_ack_legacy: assert property (rd_in && (addr_in == irg_pkg::OFF_ACK_GRP0)
                                  && st_q.cctl.ack_control_legacy && !sig0 && sig1
                                  |=> rdata_out == 32'($past(hp_id)))
      else $error("legacy ack did not take group 1 interrupt");
   a_ack_grp1: assert property (s_ack1_read ##0 !sig1 |=>
                                rdata_out == 32'(irg_pkg::ID_SPURIOUS))
      else $error("aliased ack returned an id without group 1 candidate");
   a_eoi_grp1: assert property (s_eoi1_valid |=> !st_q.active[$past(wdata_in[4:0])])
      else $error("aliased completion left interrupt active");
   a_eoi_grp0: assert property (s_eoi0_valid |=> !st_q.active[$past(wdata_in[4:0])])
      else $error("primary completion left group 0 interrupt active");
   a_ro_ignore: assert property (wr_in && (addr_in == irg_pkg::OFF_RUN_PRIO) |=>
                                 $stable(st_q.cctl) && $stable(st_q.dctl)
                                 && $stable(st_q.pmr) && $stable(st_q.active))
      else $error("write to read-only register changed state");
   a_wo_read: assert property (rd_in && (addr_in == irg_pkg::OFF_EOI_GRP0) |=>
                               rdata_out == 32'h0000_0000)
      else $error("write-only read returned data");
   a_bp_common: assert property (st_q.cctl.common_binary_point && hp_grp |->
                                 pre_mask == (8'hFF << (4'(st_q.bp0) + 4'h1)))
      else $error("group 1 not using primary binary point");
   a_bp_split: assert property (!st_q.cctl.common_binary_point && hp_grp |->
                                pre_mask == (8'hFF << st_q.bp1))
      else $error("group 1 not using aliased binary point");
endmodule
`default_nettype wire

// *** logic/irg_pkg.sv ***
`default_nettype none
package irg_pkg;
   localparam int NUM_IRQ = 32;
   localparam int ID_W    = 10;
   localparam int ADDR_W  = 12;

   // distributor side
   localparam logic [11:0] OFF_DIST_CTRL  = 12'h000;
   localparam logic [11:0] OFF_GROUP_ASGN = 12'h004;
   localparam logic [11:0] OFF_PENDING    = 12'h008;
   // cpu interface side
   localparam logic [11:0] OFF_CPU_CTRL   = 12'h100;
   localparam logic [11:0] OFF_PRIO_MASK  = 12'h104;
   localparam logic [11:0] OFF_BP_GRP0    = 12'h108;
   localparam logic [11:0] OFF_ACK_GRP0   = 12'h10C;
   localparam logic [11:0] OFF_EOI_GRP0   = 12'h110;
   localparam logic [11:0] OFF_RUN_PRIO   = 12'h114;
   localparam logic [11:0] OFF_HP_PEND    = 12'h118;
   localparam logic [11:0] OFF_BP_GRP1    = 12'h11C;
   localparam logic [11:0] OFF_ACK_GRP1   = 12'h120;
   localparam logic [11:0] OFF_EOI_GRP1   = 12'h124;
   // event status / mask
   localparam logic [11:0] OFF_EVT_STAT   = 12'h200;
   localparam logic [11:0] OFF_EVT_MASK   = 12'h204;

   localparam logic [9:0]  ID_SPURIOUS    = 10'h3FF;
   localparam logic [9:0]  ID_WRONG_GRP   = 10'h3FE;
   localparam logic [7:0]  RUN_PRIO_IDLE  = 8'hFF;
   localparam logic [31:0] GROUP_RESET    = 32'h0000_0000;
   localparam logic [7:0]  PMR_RESET      = 8'h00;
   localparam logic [2:0]  BP_RESET       = 3'h0;

   localparam int EVT_SPURIOUS_ACK = 0;
   localparam int EVT_BAD_EOI      = 1;

   typedef struct packed {
      logic group1_enable;
      logic group0_enable;
   } irg_dist_ctrl_t;

   typedef struct packed {
      logic common_binary_point;
      logic fiq_select_grp0;
      logic ack_control_legacy;
      logic group1_enable;
      logic group0_enable;
   } irg_cpu_ctrl_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [31:0]       wdata;
      logic              wr;
      logic              rd;
   } irg_bus_req_t;

   typedef struct packed {
      logic [NUM_IRQ-1:0] src_s1;
      logic [NUM_IRQ-1:0] src_s2;
      logic [NUM_IRQ-1:0] src_prev;
      logic [NUM_IRQ-1:0] pending;
      logic [NUM_IRQ-1:0] active;
      irg_dist_ctrl_t     dctl;
      irg_cpu_ctrl_t      cctl;
      logic [7:0]         pmr;
      logic [2:0]         bp0;
      logic [2:0]         bp1;
      logic [1:0]         evt_stat;
      logic [1:0]         evt_mask;
      logic [31:0]        rdata;
      logic               irq;
      logic               fiq;
      logic               intr;
   } irg_state_t;

   typedef struct packed {
      logic [NUM_IRQ-1:0] groups;
   } irg_store_t;
endpackage
`default_nettype wire

// *** logic/irg_grp_store.sv ***
`timescale 1ns/1ps
`default_nettype none
// group assignment bits, one per interrupt; cleared to group 0 by reset
module irg_grp_store (
   // clock and reset
   input  wire logic                        clk_in,
   input  wire logic                        rst_in,
   // write port
   input  wire logic                        wr_in,
   input  wire logic [irg_pkg::NUM_IRQ-1:0] wdata_in,
   // stored assignment
   output logic      [irg_pkg::NUM_IRQ-1:0] groups_out
);
   irg_pkg::irg_store_t st_q;
   irg_pkg::irg_store_t st_d;

   always_comb begin
      st_d = st_q;
      if (wr_in) begin
         st_d.groups = wdata_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         st_q.groups <= irg_pkg::GROUP_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   assign groups_out = st_q.groups;
endmodule
`default_nettype wire

// *** testbench/irg_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module irg_core_model (
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   // requests from the controller
   input  wire logic       irq_in,
   input  wire logic       fiq_in,
   // exceptions entered so far
   output logic      [7:0] irq_taken_out,
   output logic      [7:0] fiq_taken_out
);
   logic irq_q;
   logic fiq_q;

   // a core only sees levels, so each rising edge counts as one exception entry
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         irq_q         <= 1'b0;
         fiq_q         <= 1'b0;
         irq_taken_out <= 8'h00;
         fiq_taken_out <= 8'h00;
      end else begin
         irq_q <= irq_in;
         fiq_q <= fiq_in;
         if (irq_in && !irq_q) begin
            irq_taken_out <= irq_taken_out + 8'h01;
         end
         if (fiq_in && !fiq_q) begin
            fiq_taken_out <= fiq_taken_out + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// *** testbench/tb_interrupt_group_routing.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_group_routing;
   logic        clk_in    = 1'b0;
   logic        rst_in    = 1'b1;
   logic [31:0] src_in    = 32'h0000_0000;
   logic [11:0] addr_in   = 12'h000;
   logic [31:0] wdata_in  = 32'h0000_0000;
   logic        wr_in     = 1'b0;
   logic        rd_in     = 1'b0;
   logic [31:0] rdata_out;
   logic        irq_out;
   logic        fiq_out;
   logic        int_out;
   logic [7:0]  irq_taken;
   logic [7:0]  fiq_taken;
   int          err_total = 0;
   int          tests_run = 0;

   always #25 clk_in = ~clk_in;

   irg_router irg_router_inst (
      .clk_in    (clk_in),
      .rst_in    (rst_in),
      .src_in    (src_in),
      .addr_in   (addr_in),
      .wdata_in  (wdata_in),
      .wr_in     (wr_in),
      .rd_in     (rd_in),
      .rdata_out (rdata_out),
      .irq_out   (irq_out),
      .fiq_out   (fiq_out),
      .int_out   (int_out)
   );

   irg_core_model irg_core_model_inst (
      .clk_in        (clk_in),
      .rst_in        (rst_in),
      .irq_in        (irq_out),
      .fiq_in        (fiq_out),
      .irq_taken_out (irq_taken),
      .fiq_taken_out (fiq_taken)
   );

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk1(input string what, input logic exp, input logic got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask

   // strobes start one edge after the task is entered, so back-to-back calls never
   // assign a strobe twice in one time step
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
      @(posedge clk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      chk32(what, exp, rdata_out);
   endtask

   // quiet=1: requests must be at the given levels 8 cycles later; else wait for them
   task automatic req(input logic ei, input logic ef, input logic quiet);
      int i;
      if (quiet) begin
         repeat (8) @(posedge clk_in);
         #1;
      end else begin
         for (i = 0; i < 20 && !(irq_out === ei && fiq_out === ef); i++) begin
            @(posedge clk_in);
            #1;
         end
      end
      chk1("irq_out", ei, irq_out);
      chk1("fiq_out", ef, fiq_out);
   endtask

   task automatic int_chk(input logic e);
      repeat (3) @(posedge clk_in);
      #1;
      chk1("int_out", e, int_out);
   endtask

   task automatic raise(input int id);
      @(posedge clk_in);
      src_in[id] <= 1'b1;
   endtask

   initial begin
      repeat (10) @(posedge clk_in);
      rst_in <= 1'b0;
      rd(irg_pkg::OFF_GROUP_ASGN, 32'h0000_0000, "groups");
      rd(irg_pkg::OFF_DIST_CTRL, 32'h0000_0000, "dist ctrl");
      rd(irg_pkg::OFF_CPU_CTRL, 32'h0000_0000, "cpu ctrl");
      rd(irg_pkg::OFF_RUN_PRIO, 32'h0000_00FF, "run prio");
      wr(irg_pkg::OFF_GROUP_ASGN, 32'h0000_0022);
      rd(irg_pkg::OFF_GROUP_ASGN, 32'h0000_0022, "groups");
      wr(irg_pkg::OFF_PENDING, 32'hFFFF_FFFF);
      rd(irg_pkg::OFF_PENDING, 32'h0000_0000, "pending");
      wr(irg_pkg::OFF_RUN_PRIO, 32'h0000_0000);
      rd(irg_pkg::OFF_RUN_PRIO, 32'h0000_00FF, "run prio");
      rd(irg_pkg::OFF_EOI_GRP0, 32'h0000_0000, "completion");
      rd(12'h300, 32'h0000_0000, "unmapped");
      wr(irg_pkg::OFF_DIST_CTRL, 32'h0000_0003);
      wr(irg_pkg::OFF_PRIO_MASK, 32'h0000_00FF);
      // group 1 on irq while group 0 is steered to fiq
      wr(irg_pkg::OFF_CPU_CTRL, 32'h0000_000B);
      raise(1);
      req(1'b1, 1'b0, 1'b0);
      rd(irg_pkg::OFF_ACK_GRP0, 32'h0000_03FE, "ack grp0");
      rd(irg_pkg::OFF_ACK_GRP1, 32'h0000_0001, "ack grp1");
      req(1'b0, 1'b0, 1'b0);
      wr(irg_pkg::OFF_EOI_GRP1, 32'h0000_0001);
      rd(irg_pkg::OFF_RUN_PRIO, 32'h0000_00FF, "run prio");
      raise(0);
      req(1'b0, 1'b1, 1'b0);
      rd(irg_pkg::OFF_ACK_GRP0, 32'h0000_0000, "ack grp0");
      rd(irg_pkg::OFF_RUN_PRIO, 32'h0000_0000, "run prio");
      wr(irg_pkg::OFF_EOI_GRP0, 32'h0000_0000);
      rd(irg_pkg::OFF_RUN_PRIO, 32'h0000_00FF, "run prio");
      // without fiq select group 0 falls back to irq
      wr(irg_pkg::OFF_CPU_CTRL, 32'h0000_0003);
      raise(2);
      req(1'b1, 1'b0, 1'b0);
      rd(irg_pkg::OFF_ACK_GRP0, 32'h0000_0002, "ack grp0");
      wr(irg_pkg::OFF_EOI_GRP0, 32'h0000_0002);
      wr(irg_pkg::OFF_DIST_CTRL, 32'h0000_0002);
      raise(3);
      req(1'b0, 1'b0, 1'b1);
      wr(irg_pkg::OFF_DIST_CTRL, 32'h0000_0003);
      req(1'b1, 1'b0, 1'b0);
      rd(irg_pkg::OFF_ACK_GRP0, 32'h0000_0003, "ack grp0");
      wr(irg_pkg::OFF_EOI_GRP0, 32'h0000_0003);
      wr(irg_pkg::OFF_CPU_CTRL, 32'h0000_0001);
      raise(5);
      req(1'b0, 1'b0, 1'b1);
      // legacy mode: primary registers serve group 1 as well
      wr(irg_pkg::OFF_CPU_CTRL, 32'h0000_0007);
      req(1'b1, 1'b0, 1'b0);
      rd(irg_pkg::OFF_ACK_GRP0, 32'h0000_0005, "ack legacy");
      wr(irg_pkg::OFF_EOI_GRP0, 32'h0000_0005);
      rd(irg_pkg::OFF_RUN_PRIO, 32'h0000_00FF, "run prio");
      wr(irg_pkg::OFF_BP_GRP0, 32'h0000_0002);
      wr(irg_pkg::OFF_BP_GRP1, 32'h0000_0006);
      rd(irg_pkg::OFF_BP_GRP0, 32'h0000_0002, "bp grp0");
      rd(irg_pkg::OFF_BP_GRP1, 32'h0000_0006, "bp grp1");
      // group 1 preemption: split points block id 8 over active id 9, common point lets it in
      wr(irg_pkg::OFF_GROUP_ASGN, 32'h0000_0322);
      wr(irg_pkg::OFF_CPU_CTRL, 32'h0000_0003);
      raise(9);
      req(1'b1, 1'b0, 1'b0);
      rd(irg_pkg::OFF_ACK_GRP1, 32'h0000_0009, "ack grp1");
      raise(8);
      req(1'b0, 1'b0, 1'b1);
      rd(irg_pkg::OFF_RUN_PRIO, 32'h0000_0048, "run prio");
      rd(irg_pkg::OFF_HP_PEND, 32'h0000_03FF, "hp pend");
      wr(irg_pkg::OFF_CPU_CTRL, 32'h0000_0013);
      req(1'b1, 1'b0, 1'b0);
      rd(irg_pkg::OFF_HP_PEND, 32'h0000_0008, "hp pend");
      rd(irg_pkg::OFF_ACK_GRP1, 32'h0000_0008, "ack grp1");
      wr(irg_pkg::OFF_EOI_GRP1, 32'h0000_0008);
      wr(irg_pkg::OFF_EOI_GRP1, 32'h0000_0009);
      rd(irg_pkg::OFF_RUN_PRIO, 32'h0000_00FF, "run prio");
      wr(irg_pkg::OFF_CPU_CTRL, 32'h0000_0010);
      rd(irg_pkg::OFF_CPU_CTRL, 32'h0000_0010, "cpu ctrl");
      rd(irg_pkg::OFF_ACK_GRP1, 32'h0000_03FF, "ack spurious");
      // event status: bit 0 set by the wrong-group and spurious acks above
      rd(irg_pkg::OFF_EVT_STAT, 32'h0000_0001, "evt stat");
      int_chk(1'b0);
      wr(irg_pkg::OFF_EVT_MASK, 32'h0000_0003);
      int_chk(1'b1);
      wr(irg_pkg::OFF_EVT_STAT, 32'h0000_0001);
      int_chk(1'b0);
      wr(irg_pkg::OFF_EOI_GRP1, 32'h0000_0007);
      rd(irg_pkg::OFF_EVT_STAT, 32'h0000_0002, "evt stat");
      int_chk(1'b1);
      wr(irg_pkg::OFF_EVT_MASK, 32'h0000_0001);
      int_chk(1'b0);
      chk32("irq taken", 32'h0000_0006, {24'h000000, irq_taken});
      chk32("fiq taken", 32'h0000_0001, {24'h000000, fiq_taken});
      // a second reset after reassignment must put every interrupt back in group 0
      @(posedge clk_in);
      rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      rd(irg_pkg::OFF_GROUP_ASGN, 32'h0000_0000, "groups");
      rd(irg_pkg::OFF_DIST_CTRL, 32'h0000_0000, "dist ctrl");
      print_verdict();
   end
endmodule
`default_nettype wire
